//--- include/link_pulse_pkg.sv
// Constants and types for the link pulse generator
// Contract
// - Idle 10BASE-T: 100 ns pulse every 16 ms
// - Burst clock and data pulses 100 ns wide
// - Burst clock pulses start 125 us apart
// - One bit: data pulse 62 us after clock
// - Burst spans 2 ms first to last pulse
// - Burst starts 16 ms apart
// - Timings are transmit values, not receive windows
`default_nettype none
package link_pulse_pkg;
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned PULSE_NS     = 100;
  localparam int unsigned PERIOD_MS    = 16;
  localparam int unsigned CLK_SPACE_US = 125;
  localparam int unsigned DATA_OFS_US  = 62;
  localparam int unsigned BURST_MS     = 2;
  // Cycle counts; widths round down, none below one cycle
  localparam int unsigned PULSE_CYC    =
    (PULSE_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned PERIOD_CYC   = PERIOD_MS * (CLK_HZ / 1000);
  localparam int unsigned CLK_SPACE_CYC =
    CLK_SPACE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned DATA_OFS_CYC =
    DATA_OFS_US * (CLK_HZ / 1_000_000);
  localparam int unsigned BURST_CYC    = BURST_MS * (CLK_HZ / 1000);
  // 2 ms / 125 us gives 16 slots, 17 clock pulses span the burst
  localparam int unsigned SLOTS        = BURST_CYC / CLK_SPACE_CYC;
  localparam int unsigned CNT_W        = 20;
  localparam int unsigned PAGE_W       = 16;
  localparam logic [4:0]  SLOT_ZERO    = 5'h00;

  typedef enum logic [1:0] {
    MODE_OFF   = 2'h0,
    MODE_NLP   = 2'h1,
    MODE_BURST = 2'h2
  } pulse_mode_t;

  typedef struct packed {
    logic pulse;
    logic clock_pulse;
    logic data_pulse;
    logic burst_active;
  } pulse_out_t;
endpackage
`default_nettype wire

//--- logic/link_pulse_generator.sv
// Normal link pulse and negotiation pulse burst transmit generator
`default_nettype none

// ------------------------------------------------------------------
// Two-stage synchroniser for level pins
// ------------------------------------------------------------------
module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] pin_in,
  output var  logic [WIDTH-1:0] sync_q
);
  // Only the second stage is read, so a metastable first stage never
  // reaches the timers
  logic [WIDTH-1:0] meta_q;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end
endmodule

// ------------------------------------------------------------------
// Link pulse generator
// ------------------------------------------------------------------
module link_pulse_generator
  import link_pulse_pkg::*;
#(
  parameter int unsigned PERIOD_CYCLES = PERIOD_CYC,
  parameter int unsigned SPACE_CYCLES  = CLK_SPACE_CYC,
  parameter int unsigned DATA_CYCLES   = DATA_OFS_CYC,
  parameter int unsigned PULSE_CYCLES  = PULSE_CYC,
  parameter int unsigned NUM_SLOTS     = SLOTS
) (
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic [1:0]       mode_pin,
  input  wire logic [PAGE_W-1:0] page_pin,
  output var  pulse_out_t       tx_q
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Page bits are static levels; a mixed word is taken only at period
  // start, long after the pins have settled
  logic [1:0]        mode_s2_q;
  logic [PAGE_W-1:0] page_s2_q;

  pin_sync #(
    .WIDTH ($bits(mode_pin))
  ) i_mode_sync (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .pin_in  (mode_pin),
    .sync_q  (mode_s2_q)
  );

  pin_sync #(
    .WIDTH (PAGE_W)
  ) i_page_sync (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .pin_in  (page_pin),
    .sync_q  (page_s2_q)
  );

  // ----------------------------------------------------------------
  // Period and slot timers
  // ----------------------------------------------------------------
  // Mode changes are taken only at period start so a burst is never cut;
  // pin code 3 is not decoded and keeps the line quiet
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_LINK  = 4'b0010,
    ST_BURST = 4'b0100,
    ST_TAIL  = 4'b1000
  } seq_state_t;

  seq_state_t        state_q;
  seq_state_t        state_d;
  seq_state_t        start_state;
  logic [PAGE_W-1:0] page_q;
  logic [CNT_W-1:0]  period_cnt_q;
  logic [CNT_W-1:0]  slot_cnt_q;
  logic [4:0]        slot_q;
  logic              period_start;
  logic              slot_end;
  assign period_start = (period_cnt_q == CNT_W'(PERIOD_CYCLES - 1));
  assign slot_end     = (slot_cnt_q == CNT_W'(SPACE_CYCLES - 1));

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      period_cnt_q <= '0;
    end else if (period_start) begin
      period_cnt_q <= '0;
    end else begin
      period_cnt_q <= period_cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      page_q <= '0;
    end else if (period_start) begin
      page_q <= page_s2_q;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      slot_cnt_q <= '0;
    end else if (period_start || slot_end) begin
      slot_cnt_q <= '0;
    end else begin
      slot_cnt_q <= slot_cnt_q + CNT_W'(1);
    end
  end

  // Slot index saturates one past the last slot so the tail stays quiet
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      slot_q <= SLOT_ZERO;
    end else if (period_start) begin
      slot_q <= SLOT_ZERO;
    end else if (slot_end && (slot_q <= 5'(NUM_SLOTS))) begin
      slot_q <= slot_q + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    case (mode_s2_q)
      MODE_NLP:   start_state = ST_LINK;
      MODE_BURST: start_state = ST_BURST;
      default:    start_state = ST_IDLE;
    endcase
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (period_start) begin
          state_d = start_state;
        end
      end
      ST_LINK: begin
        if (period_start) begin
          state_d = start_state;
        end
      end
      ST_BURST: begin
        if (period_start) begin
          state_d = start_state;
        end else if (slot_end && (slot_q == 5'(NUM_SLOTS))) begin
          state_d = ST_TAIL;
        end
      end
      ST_TAIL: begin
        if (period_start) begin
          state_d = start_state;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Pulse triggers
  // ----------------------------------------------------------------
  // Timings drive the transmitter only; nothing here judges received
  // pulses
  logic in_burst;
  logic clk_fire;
  logic data_fire;
  logic data_bit;
  assign in_burst = (state_q == ST_BURST);
  assign data_bit = (slot_q < 5'(PAGE_W)) ? page_q[slot_q[3:0]] : 1'b0;
  assign clk_fire = (state_q == ST_LINK) ? (period_cnt_q == '0)
                  : (in_burst && slot_cnt_q == '0);
  // Zero bit leaves the data slot empty
  assign data_fire = in_burst && (slot_q < 5'(NUM_SLOTS))
                  && (slot_cnt_q == CNT_W'(DATA_CYCLES))
                  && data_bit;

  // ----------------------------------------------------------------
  // Pulse width shaper
  // ----------------------------------------------------------------
  // The fire cycle is the first of the pulse, so the counter only has
  // to hold the line for the remaining cycles
  logic [7:0] width_cnt_q;
  logic       is_data_q;
  logic       width_live;
  pulse_out_t tx_d;
  assign width_live = (width_cnt_q > 8'h01);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      width_cnt_q <= 8'h00;
    end else if (clk_fire || data_fire) begin
      width_cnt_q <= 8'(PULSE_CYCLES);
    end else if (width_cnt_q != 8'h00) begin
      width_cnt_q <= width_cnt_q - 8'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      is_data_q <= 1'b0;
    end else if (clk_fire || data_fire) begin
      is_data_q <= data_fire;
    end
  end

  // ----------------------------------------------------------------
  // Output register
  // ----------------------------------------------------------------
  always_comb begin
    tx_d              = '0;
    tx_d.clock_pulse  = clk_fire || (width_live && !is_data_q);
    tx_d.data_pulse   = data_fire || (width_live && is_data_q);
    tx_d.pulse        = tx_d.clock_pulse || tx_d.data_pulse;
    tx_d.burst_active = in_burst;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_q <= '0;
    end else begin
      tx_q <= tx_d;
    end
  end
endmodule
`default_nettype wire

//--- verif/link_pulse_sva.sv
// Assertions on the link pulse generator outputs
`default_nettype none
module link_pulse_sva
  import link_pulse_pkg::*;
#(
  parameter int unsigned PERIOD_CYCLES = PERIOD_CYC,
  parameter int unsigned SPACE_CYCLES  = CLK_SPACE_CYC,
  parameter int unsigned DATA_CYCLES   = DATA_OFS_CYC
) (
  input wire logic              sys_clk,
  input wire logic              reset_n,
  input wire logic [1:0]        mode_pin,
  input wire logic [PAGE_W-1:0] page_pin,
  input wire pulse_out_t        tx_q
);
  // ------------------------------------------------------------------
  // Period of pulse or burst starts
  // ------------------------------------------------------------------
  logic [1:0]  hist_q;
  logic [19:0] gap_q;
  logic [19:0] off_cnt_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // A start is a clock pulse after a quiet cycle outside any burst
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      hist_q <= 2'h0;
      gap_q  <= 20'h00000;
    end else begin
      hist_q <= {tx_q.clock_pulse, tx_q.burst_active};
      if (tx_q.clock_pulse && hist_q == 2'h0) gap_q <= 20'h00001;
      else if (gap_q != 20'h00000) gap_q <= gap_q + 20'h00001;
    end
  end
  // Cycles the mode pins have asked for a quiet line
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      off_cnt_q <= 20'h00000;
    end else if (mode_pin == MODE_NLP || mode_pin == MODE_BURST) begin
      off_cnt_q <= 20'h00000;
    end else if (off_cnt_q != 20'hfffff) begin
      off_cnt_q <= off_cnt_q + 20'h00001;
    end
  end
  chk_line_width: assert property ($rose(tx_q.pulse) |=>
    tx_q.pulse ##1 !tx_q.pulse) else $error("line pulse width");
  chk_clock_width: assert property ($rose(tx_q.clock_pulse) |=>
    tx_q.clock_pulse ##1 !tx_q.clock_pulse) else $error("clock width");
  chk_data_width: assert property ($rose(tx_q.data_pulse) |=>
    tx_q.data_pulse ##1 !tx_q.data_pulse) else $error("data width");
  chk_pulse_kind: assert property (tx_q.pulse |->
    tx_q.clock_pulse || tx_q.data_pulse) else $error("pulse kind");
  chk_clock_space: assert property ($rose(tx_q.clock_pulse) &&
    $past(tx_q.burst_active, 4) |-> $past(tx_q.clock_pulse, SPACE_CYCLES)
    && !$past(tx_q.clock_pulse, SPACE_CYCLES + 1)) else $error("spacing");
  chk_data_offset: assert property ($rose(tx_q.data_pulse) |->
    $past(tx_q.clock_pulse, DATA_CYCLES) &&
    !$past(tx_q.clock_pulse, DATA_CYCLES + 1)) else $error("data offset");
  chk_data_burst: assert property ($rose(tx_q.data_pulse) |->
    tx_q.burst_active) else $error("data pulse outside burst");
  chk_start_period: assert property (tx_q.clock_pulse &&
    hist_q == 2'h0 && gap_q != 20'h00000 |-> gap_q % PERIOD_CYCLES == 0)
    else $error("start period");
  chk_off_quiet: assert property (off_cnt_q > 20'(PERIOD_CYCLES + 4) |->
    !tx_q.pulse) else $error("pulse while off");
endmodule
bind link_pulse_generator link_pulse_sva #(
  .PERIOD_CYCLES(PERIOD_CYCLES), .SPACE_CYCLES(SPACE_CYCLES),
  .DATA_CYCLES(DATA_CYCLES)) i_link_pulse_sva (.sys_clk(sys_clk),
  .reset_n(reset_n), .mode_pin(mode_pin), .page_pin(page_pin), .tx_q(tx_q));
`default_nettype wire

//--- verif/link_rx.sv
// Link partner receiver model that counts line pulses
`default_nettype none
module link_rx (
  input  wire logic        sys_clk,
  input  wire logic        line,
  output var  logic [15:0] seen
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        last_q  = 1'b0;
  logic [15:0] count_q = 16'h0000;
  assign seen = count_q;
  // Counts edges only; widths are no acceptance window
  always @(posedge sys_clk) begin
    if (line && !last_q) count_q <= count_q + 16'h0001;
    last_q <= line;
  end
endmodule
`default_nettype wire

//--- verif/testbench.sv
// Testbench for the link pulse generator
`default_nettype none
module testbench
  import link_pulse_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk  = 1'b0;
  logic        reset_n  = 1'b0;
  logic [1:0]  mode_pin = 2'h0;
  logic [15:0] page_pin = 16'h0000;
  logic [15:0] seen;
  pulse_out_t  tx_q;
  int          miscompares = 0;
  int          checked     = 0;
  // Short counts keep the run small; ratios differ from the real timing, a period is 20 slots not 128
  link_pulse_generator #(.PERIOD_CYCLES(400), .SPACE_CYCLES(20),
    .DATA_CYCLES(10)) i_link_pulse_generator (.sys_clk(sys_clk),
    .reset_n(reset_n), .mode_pin(mode_pin), .page_pin(page_pin),
    .tx_q(tx_q));
  link_rx i_link_rx (.sys_clk(sys_clk), .line(tx_q.pulse), .seen(seen));
  initial forever #25 sys_clk = ~sys_clk;
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Negedges until the next rising clock pulse, bounded
  task automatic rise(output int n);
    logic p;
    n = 0;
    p = 1'b1;
    while (n < 2000 && !(tx_q.clock_pulse && !p)) begin
      p = tx_q.clock_pulse;
      @(negedge sys_clk);
      n++;
    end
  endtask
  task automatic test_nlp;
    int n;
    mode_pin = 2'h1;
    rise(n);
    rise(n);
    cmp(16'(n), 16'h0190);
    $display("test_nlp done");
  endtask
  task automatic test_burst;
    int n;
    logic [15:0] bits;
    logic [15:0] s0;
    page_pin = 16'ha5c3;
    mode_pin = 2'h2;
    do rise(n); while (!(tx_q.burst_active && n > 20));
    s0 = seen;
    for (int k = 0; k < 16; k++) begin
      repeat (10) @(negedge sys_clk);
      bits[k] = tx_q.data_pulse;
      rise(n);
      cmp(16'(n), 16'h000a);
    end
    cmp(bits, 16'ha5c3);
    cmp(seen - s0, 16'h0018);
    rise(n);
    cmp(16'(n), 16'h0050);
    $display("test_burst done");
  endtask
  task automatic test_off;
    logic [15:0] s0;
    mode_pin = 2'h0;
    repeat (404) @(negedge sys_clk);
    s0 = seen;
    repeat (800) @(negedge sys_clk);
    cmp(seen - s0, 16'h0000);
    cmp(16'(tx_q.burst_active), 16'h0000);
    $display("test_off done");
  endtask
  task automatic close_out;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge sys_clk);
    reset_n = 1'b1;
    test_nlp;
    test_burst;
    test_off;
    close_out;
  end
  initial begin
    repeat (6000) @(posedge sys_clk);
    miscompares++;
    close_out;
  end
endmodule
`default_nettype wire
